// File: core/tef_extract_flow.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "tef_defs.svh"

// Register map, eight bits each
//   0x1d8 T1 start [3:0], E1 start [7:4]
//   0x1d9 DS3 start [3:0], E3 start [7:4]
//   0x1da T1 upper [3:0], lower [7:4]
//   0x1db E1 levels, same layout
//   0x1dc DS3 levels, upper plus 16
//   0x1dd E3 levels, upper plus 16
//   0x1de Error group, link and flag
//   0x1df Empty [7], fraction [6],
//         internal [1], frame [0]
//   0x1f0 Auto reset enable [0]
//   0x1f1 Interrupt mask [2:0]
//   0x1f2 Interrupt status [2:0]
//
// Reset values
//   Start registers 0x77 and 0xfe
//   Level registers 0x2d
//   Auto reset on, mask clear
//   Request memory all ones
//   Status and pending all clear
//
// Register port
//   Writes land on the next edge
//   Read data stand one cycle
//   Idle read data are zero
//   No wait states
//   Status writes are dropped
//   Unmapped reads return zero
//
// Link visits
//   One link per valid cycle
//   Answer one cycle later
//   Answer stands one cycle
//   State kept per group and link
//   Flops, not RAM: any link, any cycle
//
// Start depth
//   Held until start level reached
//   Released until empty or reset
//   Empty link never readable
//   Start levels top out at 15
//
// Level justification
//   Master, non-fractional links only
//   Positive above upper level
//   Negative below lower level
//   Quiet inside the window
//   Crossed levels fire both flags;
//   software keeps them ordered
//
// Fractional flow
//   Request off above the level
//   Request on below the level
//   Equal depth keeps last request
//   Output echoes one visit only,
//   so sample it in the answer cycle
//   Link reset raises the request
//
// Empty handling
//   Stuff flagged only while clear
//   Stuff on empty shifts the stream
//
// Depth errors
//   Each error marks its link
//   Read pops the highest link
//   Flag stays while more remain
//   A failing link can starve
//   lower links in the encoder
//   Error beats manual reset only
//   while auto reset is on
//
// Realignment
//   Frame pin passes two flops
//   First edge only aligns count
//   Off-count edge is a realign
//   Internal pulse is same-clock
//   Frame period is a parameter
//
// Interrupts
//   Sticky bits, set beats clear
//   Output high on masked-in bit
//
// Limitations
//   Request is not held between
//   visits; far end must latch it
//   One error entry per read
//   Levels are not range checked
module tef_extract_flow #(
   parameter int FRAME_CYCLES = `TEF_FRAME_CYCLES  // Add bus frame period in clocks
) (
   // Clock and reset
   input  wire logic                  mclk_in,
   input  wire logic                  rst_in,
   // Register port
   input  wire tef_pkg::tef_bus_s     bus_in,
   output logic [7:0]                 rd_data_out,
   // Link visits and answers
   input  wire tef_pkg::tef_link_s    link_in,
   output tef_pkg::tef_answer_s       answer_out,
   output logic                       justify_request_out,
   // Link errors and resets
   input  wire tef_pkg::tef_link_ev_s depth_err_in,
   input  wire tef_pkg::tef_link_ev_s manual_reset_in,
   output tef_pkg::tef_link_ev_s      link_reset_out,
   // Realignment sources
   input  wire logic                  add_bus_frame_pulse_in,
   input  wire logic                  internal_bus_realign_in,
   // Interrupt
   output logic                       irq_out
);

   tef_pkg::tef_state_s s;       // Registered state
   tef_pkg::tef_state_s next_s;  // Next state

   // Highest-numbered pending link wins, like the other error encoders
   function automatic logic [6:0] top_pending(input logic [127:0] p);
      logic [6:0] idx;
      idx = 7'h00;
      for (int k = 0; k < 128; k++) begin
         if (p[k]) begin
            idx = 7'(k);
         end
      end
      return idx;
   endfunction

   // Widen a 4-bit level field to depth width
   function automatic logic [`TEF_DEPTH_W-1:0] widen(input logic [3:0] f);
      return {{(`TEF_DEPTH_W-4){1'b0}}, f};
   endfunction

   logic [6:0]              lidx;      // Array index of presented link
   logic [6:0]              top_idx;   // Pending link reported next
   logic [7:0]              thr_sel;   // Threshold byte for the rate
   logic [3:0]              start_f;   // Start depth field for the rate
   logic [`TEF_DEPTH_W-1:0] upper;     // Effective upper level
   logic [`TEF_DEPTH_W-1:0] lower;     // Effective lower level
   logic [`TEF_DEPTH_W-1:0] fract_thr; // Fractional flow level
   logic                    started;   // Reader released for this link
   logic                    fp_rise;   // Synchronised frame pulse edge
   logic [6:0]              ridx;      // Index of link being reset

   // Group and link form a 7-bit index over 128 entries
   assign lidx    = {link_in.payload_group_index, link_in.link};
   assign top_idx = top_pending(s.pending);

   // Select levels from the link's tributary rate
   always_comb begin
      thr_sel = s.thr_t1;
      start_f = s.low_start[3:0];
      case (link_in.rate)
         tef_pkg::TEF_RATE_T1: begin
            thr_sel = s.thr_t1;
            start_f = s.low_start[3:0];
         end
         tef_pkg::TEF_RATE_E1: begin
            thr_sel = s.thr_e1;
            start_f = s.low_start[7:4];
         end
         tef_pkg::TEF_RATE_DS3: begin
            thr_sel = s.thr_ds3;
            start_f = s.high_start[3:0];
         end
         tef_pkg::TEF_RATE_E3: begin
            thr_sel = s.thr_e3;
            start_f = s.high_start[7:4];
         end
         default: begin
            thr_sel = s.thr_t1;
            start_f = s.low_start[3:0];
         end
      endcase
   end

   // High-rate links get sixteen bytes of headroom on the upper level
   always_comb begin
      upper = widen(thr_sel[3:0]);
      if (link_in.rate == tef_pkg::TEF_RATE_DS3 || link_in.rate == tef_pkg::TEF_RATE_E3) begin
         upper = widen(thr_sel[3:0]) + `TEF_MAX_OFFSET;
      end
      lower = widen(thr_sel[7:4]);
      fract_thr = s.flow_cfg[1] ? `TEF_FRACT_HIGH : `TEF_FRACT_LOW;
   end

   // Reader is released once depth reaches the start level
   assign started = s.started[lidx] || (link_in.depth >= widen(start_f));

   // Frame edge only from the second synchroniser stage onward
   assign fp_rise = s.fp_sync[1] && !s.fp_prev;

   // Reset target follows the same choice as the reset pulse itself
   assign ridx = (depth_err_in.valid && s.auto_reset_on_depth_error)
                 ? {depth_err_in.payload_group_index, depth_err_in.link}
                 : {manual_reset_in.payload_group_index, manual_reset_in.link};

   // Next-state logic for registers, flow decisions and event flags
   always_comb begin
      // Pulses and read data fall back to zero each cycle
      next_s = s;
      next_s.rdata = 8'h00;
      next_s.ans = '0;
      next_s.rst_ev = '0;

      // Per-link flow decisions
      if (link_in.valid) begin
         next_s.ans.valid = 1'b1;
         next_s.ans.payload_group_index   = link_in.payload_group_index;
         next_s.ans.link  = link_in.link;
         next_s.started[lidx] = started && (link_in.depth != '0);
         next_s.ans.read_ok = started && (link_in.depth != '0);
         // Slave links follow the incoming rate and never justify by level
         if (link_in.master && !link_in.fractional) begin
            next_s.ans.just_pos = link_in.depth > upper;
            next_s.ans.just_neg = link_in.depth < lower;
         end
         // Equal depth keeps the previous request, avoiding chatter
         if (link_in.fractional) begin
            if (link_in.depth > fract_thr) begin
               next_s.jreq_mem[lidx] = 1'b0;
            end else if (link_in.depth < fract_thr) begin
               next_s.jreq_mem[lidx] = 1'b1;
            end
            next_s.ans.justify_req = next_s.jreq_mem[lidx];
         end
         // Empty FIFO emits stuff only when the global bit is clear
         next_s.ans.emit_stuff = (link_in.depth == '0) && !s.flow_cfg[0];
      end

      // Link resets, auto on error or by hand; error wins the cycle
      if (depth_err_in.valid && s.auto_reset_on_depth_error) begin
         next_s.rst_ev = depth_err_in;
         next_s.started[ridx] = 1'b0;
         next_s.jreq_mem[ridx] = 1'b1;
      end else if (manual_reset_in.valid) begin
         next_s.rst_ev = manual_reset_in;
         next_s.started[ridx] = 1'b0;
         next_s.jreq_mem[ridx] = 1'b1;
      end

      // Frame pulse synchroniser and frame counter
      // Counter free-runs, so a missing pulse is not flagged
      next_s.fp_sync = {s.fp_sync[0], add_bus_frame_pulse_in};
      next_s.fp_prev = s.fp_sync[1];
      if (fp_rise) begin
         next_s.frame_cnt = 16'h0000;
         next_s.fp_locked = 1'b1;
      end else if (s.frame_cnt == 16'(FRAME_CYCLES - 1)) begin
         next_s.frame_cnt = 16'h0000;
      end else begin
         next_s.frame_cnt = s.frame_cnt + 16'h0001;
      end

      // Register writes
      // Only the two flow bits of the realign register are writable
      if (bus_in.wr) begin
         case (bus_in.addr)
            `TEF_OFF_LOW_START:  next_s.low_start  = bus_in.wdata;
            `TEF_OFF_HIGH_START: next_s.high_start = bus_in.wdata;
            `TEF_OFF_T1_THR:     next_s.thr_t1     = bus_in.wdata;
            `TEF_OFF_E1_THR:     next_s.thr_e1     = bus_in.wdata;
            `TEF_OFF_DS3_THR:    next_s.thr_ds3    = bus_in.wdata;
            `TEF_OFF_E3_THR:     next_s.thr_e3     = bus_in.wdata;
            `TEF_OFF_REALIGN: begin
               next_s.flow_cfg = {bus_in.wdata[`TEF_CFG_FRACT_BIT],
                                  bus_in.wdata[`TEF_CFG_EMPTY_BIT]};
            end
            `TEF_OFF_CONTROL: begin
               next_s.auto_reset_on_depth_error = bus_in.wdata[`TEF_CTL_AUTO_BIT];
            end
            `TEF_OFF_INT_MASK:   next_s.int_mask   = bus_in.wdata[2:0];
            default: begin
               // Status and unmapped writes are ignored
            end
         endcase
      end

      // Register reads, some of which clear what they report
      if (bus_in.rd) begin
         case (bus_in.addr)
            `TEF_OFF_LOW_START:  next_s.rdata = s.low_start;
            `TEF_OFF_HIGH_START: next_s.rdata = s.high_start;
            `TEF_OFF_T1_THR:     next_s.rdata = s.thr_t1;
            `TEF_OFF_E1_THR:     next_s.rdata = s.thr_e1;
            `TEF_OFF_DS3_THR:    next_s.rdata = s.thr_ds3;
            `TEF_OFF_E3_THR:     next_s.rdata = s.thr_e3;
            `TEF_OFF_DEPTH_ERR: begin
               // Pop one entry; flag stays up while more remain
               if (|s.pending) begin
                  next_s.rdata = {top_idx, 1'b1};
                  next_s.pending[top_idx] = 1'b0;
               end
            end
            `TEF_OFF_REALIGN: begin
               // Empty select sits above the fractional select
               next_s.rdata = {s.flow_cfg[0], s.flow_cfg[1], 4'h0, s.realign};
               next_s.realign = 2'b00;
            end
            `TEF_OFF_CONTROL: begin
               next_s.rdata = {7'h00, s.auto_reset_on_depth_error};
            end
            `TEF_OFF_INT_MASK:   next_s.rdata = {5'h00, s.int_mask};
            `TEF_OFF_INT_STATUS: begin
               next_s.rdata = {5'h00, s.int_status};
               next_s.int_status = 3'b000;
            end
            default:             next_s.rdata = 8'h00;
         endcase
      end

      // Events last, so a set in a clearing cycle is kept
      if (depth_err_in.valid) begin
         next_s.pending[{depth_err_in.payload_group_index, depth_err_in.link}] = 1'b1;
         next_s.int_status[`TEF_INT_DEPTH_BIT] = 1'b1;
      end
      // First pulse only aligns the counter, so start-up is not flagged
      if (fp_rise && s.fp_locked && s.frame_cnt != 16'(FRAME_CYCLES - 1)) begin
         next_s.realign[`TEF_RA_FP_BIT] = 1'b1;
         next_s.int_status[`TEF_INT_FP_BIT] = 1'b1;
      end
      if (internal_bus_realign_in) begin
         next_s.realign[`TEF_RA_INT_BIT] = 1'b1;
         next_s.int_status[`TEF_INT_BUS_BIT] = 1'b1;
      end
   end

   // State register; request memory idles high so links may send
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         // Configuration takes its defaults, status starts clear
         s <= '0;
         s.low_start <= `TEF_RST_LOW_START;
         s.high_start <= `TEF_RST_HIGH_START;
         s.thr_t1 <= `TEF_RST_THR;
         s.thr_e1 <= `TEF_RST_THR;
         s.thr_ds3 <= `TEF_RST_THR;
         s.thr_e3 <= `TEF_RST_THR;
         s.auto_reset_on_depth_error <= 1'(`TEF_RST_CONTROL);
         s.jreq_mem <= {128{1'b1}};
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from state
   assign rd_data_out         = s.rdata;
   assign answer_out          = s.ans;
   assign justify_request_out = s.ans.justify_req;
   assign link_reset_out      = s.rst_ev;
   // Only flops feed the interrupt, so it cannot glitch
   assign irq_out             = |(s.int_status & s.int_mask);

endmodule

// File: core/tef_defs.svh
`ifndef TEF_DEFS_SVH
`define TEF_DEFS_SVH

// Register bus geometry
`define TEF_ADDR_W          12
// Register offsets
`define TEF_OFF_LOW_START   12'h01d8
`define TEF_OFF_HIGH_START  12'h01d9
`define TEF_OFF_T1_THR      12'h01da
`define TEF_OFF_E1_THR      12'h01db
`define TEF_OFF_DS3_THR     12'h01dc
`define TEF_OFF_E3_THR      12'h01dd
`define TEF_OFF_DEPTH_ERR   12'h01de
`define TEF_OFF_REALIGN     12'h01df
`define TEF_OFF_CONTROL     12'h01f0
`define TEF_OFF_INT_MASK    12'h01f1
`define TEF_OFF_INT_STATUS  12'h01f2
// Reset values
`define TEF_RST_LOW_START   8'h77
`define TEF_RST_HIGH_START  8'hfe
`define TEF_RST_THR         8'h2d
`define TEF_RST_CONTROL     8'h01
// Field positions
`define TEF_CFG_EMPTY_BIT   7
`define TEF_CFG_FRACT_BIT   6
`define TEF_RA_INT_BIT      1
`define TEF_RA_FP_BIT       0
`define TEF_CTL_AUTO_BIT    0
`define TEF_INT_DEPTH_BIT   0
`define TEF_INT_FP_BIT      1
`define TEF_INT_BUS_BIT     2
// Depth arithmetic
`define TEF_DEPTH_W         10
`define TEF_MAX_OFFSET      10'h010
`define TEF_FRACT_LOW       10'h020
`define TEF_FRACT_HIGH      10'h100
// Timing
`define TEF_CLK_PERIOD_PS   4000
`define TEF_FRAME_TIME_NS   125000
`define TEF_FRAME_CYCLES    ((`TEF_FRAME_TIME_NS * 1000) / `TEF_CLK_PERIOD_PS)

`endif

// File: core/tef_pkg.sv
`include "tef_defs.svh"

package tef_pkg;

   // Tributary rate of a link
   typedef enum logic [1:0] {
      TEF_RATE_T1  = 2'b00,
      TEF_RATE_E1  = 2'b01,
      TEF_RATE_DS3 = 2'b10,
      TEF_RATE_E3  = 2'b11
   } tef_rate_e;

   // Register port request
   typedef struct packed {
      logic                   wr;
      logic                   rd;
      logic [`TEF_ADDR_W-1:0] addr;
      logic [7:0]             wdata;
   } tef_bus_s;

   // One link's FIFO status, presented once per visit
   typedef struct packed {
      logic                    valid;
      logic [1:0]              payload_group_index;
      logic [4:0]              link;
      tef_rate_e               rate;
      logic                    master;
      logic                    fractional;
      logic [`TEF_DEPTH_W-1:0] depth;
   } tef_link_s;

   // Flow decisions for the presented link
   typedef struct packed {
      logic       valid;
      logic [1:0] payload_group_index;
      logic [4:0] link;
      logic       read_ok;
      logic       just_pos;
      logic       just_neg;
      logic       justify_req;
      logic       emit_stuff;
   } tef_answer_s;

   // Link identity with a strobe, used for errors and resets
   typedef struct packed {
      logic       valid;
      logic [1:0] payload_group_index;
      logic [4:0] link;
   } tef_link_ev_s;

   // Whole state of the block
   typedef struct packed {
      logic [7:0]   low_start;
      logic [7:0]   high_start;
      logic [7:0]   thr_t1;
      logic [7:0]   thr_e1;
      logic [7:0]   thr_ds3;
      logic [7:0]   thr_e3;
      logic [1:0]   flow_cfg;
      logic [1:0]   realign;
      logic         auto_reset_on_depth_error;
      logic [2:0]   int_status;
      logic [2:0]   int_mask;
      logic [127:0] pending;
      logic [127:0] started;
      logic [127:0] jreq_mem;
      tef_answer_s  ans;
      tef_link_ev_s rst_ev;
      logic [7:0]   rdata;
      logic [1:0]   fp_sync;
      logic         fp_prev;
      logic         fp_locked;
      logic [15:0]  frame_cnt;
   } tef_state_s;

endpackage

// File: dv/tef_extract_flow_monitor.sv
`timescale 1ns/1ps
// Port-level watcher; start levels are four bits, so 16 bytes always suffice
module tef_extract_flow_monitor (
   input wire logic                  mclk_in,
   input wire logic                  rst_in,
   input wire tef_pkg::tef_bus_s     bus_in,
   input wire logic [7:0]            rd_data_out,
   input wire tef_pkg::tef_link_s    link_in,
   input wire tef_pkg::tef_answer_s  answer_out,
   input wire logic                  justify_request_out,
   input wire tef_pkg::tef_link_ev_s depth_err_in,
   input wire tef_pkg::tef_link_ev_s manual_reset_in,
   input wire tef_pkg::tef_link_ev_s link_reset_out,
   input wire logic                  add_bus_frame_pulse_in,
   input wire logic                  internal_bus_realign_in,
   input wire logic                  irq_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   wire       v  = link_in.valid;                         // Visit offered
   wire [9:0] d  = link_in.depth;                         // Depth offered
   wire       cm = link_in.master & ~link_in.fractional;  // Justify by levels
   wire       hi = link_in.rate[1];                       // DS3 or E3 link
   empty_hold_a: assert property (
      v && d == 0 |=> !answer_out.read_ok) else $error("empty link readable");
   deep_read_a: assert property (
      v && d > 15 |=> answer_out.read_ok) else $error("deep link held");
   pos_low_a: assert property (
      v && cm && !hi && d > 15 |=> answer_out.just_pos) else $error("no positive justify");
   pos_high_a: assert property (
      v && cm && hi && d < 17 |=> !answer_out.just_pos) else $error("upper level short");
   neg_level_a: assert property (
      v && cm && d > 15 |=> !answer_out.just_neg) else $error("negative justify too deep");
   slave_quiet_a: assert property (
      v && !cm |=> !answer_out.just_pos && !answer_out.just_neg) else $error("justify as slave");
   frac_off_a: assert property (
      v && link_in.fractional && d > 256 |=> !justify_request_out) else $error("request high");
   frac_on_a: assert property (
      v && link_in.fractional && d < 32 |=> justify_request_out) else $error("request low");
   req_cause_a: assert property (
      justify_request_out |-> $past(v) && $past(link_in.fractional)) else $error("stray request");
   manual_rst_a: assert property (
      manual_reset_in.valid && !depth_err_in.valid |=> link_reset_out == $past(manual_reset_in))
      else $error("manual reset lost");
   rst_cause_a: assert property (
      link_reset_out.valid |-> $past(depth_err_in.valid) || $past(manual_reset_in.valid))
      else $error("spurious link reset");
endmodule

bind tef_extract_flow tef_extract_flow_monitor u_mon (
   .mclk_in(mclk_in), .rst_in(rst_in), .bus_in(bus_in), .rd_data_out(rd_data_out),
   .link_in(link_in), .answer_out(answer_out), .justify_request_out(justify_request_out),
   .depth_err_in(depth_err_in), .manual_reset_in(manual_reset_in),
   .link_reset_out(link_reset_out), .add_bus_frame_pulse_in(add_bus_frame_pulse_in),
   .internal_bus_realign_in(internal_bus_realign_in), .irq_out(irq_out)
);

// File: dv/tef_far_tx.sv
`timescale 1ns/1ps
// Far-side transmitter of one fractional link; the reader takes a byte per visit
module tef_far_tx (
   input  wire logic  mclk_in,
   input  wire logic  rst_in,
   input  wire logic  justify_request_in,  // Sending allowed
   input  wire logic  slow_in,             // Answer six clocks late
   input  wire logic  take_in,             // Reader takes one byte
   output logic [9:0] depth_out            // Bytes held for the link
);
   logic [5:0] hist;                                     // Request history
   wire        go = slow_in ? hist[5] : justify_request_in;
   // Two bytes per allowed clock: request high now, or six clocks earlier when slow
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         hist      <= '0;
         depth_out <= '0;
      end else begin
         hist      <= {hist[4:0], justify_request_in};
         depth_out <= depth_out + (go ? 10'h002 : 10'h000)
                      - 10'(take_in && depth_out != '0);
      end
   end
endmodule

// File: dv/tef_extract_flow_tb.sv
`timescale 1ns/1ps
// Self-checking bench: register and flow model against the block
module tef_extract_flow_tb;
   logic                  mclk_in = 1'b0;
   logic                  rst_in  = 1'b1;
   tef_pkg::tef_bus_s     bus     = '0;
   tef_pkg::tef_link_s    lk      = '0;
   tef_pkg::tef_link_ev_s de      = '0;
   tef_pkg::tef_link_ev_s mr      = '0;
   tef_pkg::tef_link_ev_s lr;
   tef_pkg::tef_answer_s  ans;
   logic [7:0]            rd;
   logic [9:0]            fdep;                    // Partner FIFO depth
   logic                  jr, irq;
   logic                  fp = 1'b0, ib = 1'b0, slow = 1'b0;
   logic [7:0]            rm [int];                // Level registers
   logic [7:0]            cfg = 8'h00;             // Flow config bits
   logic                  au = 1'b1;               // Auto reset bit
   bit                    st [128];                // Link started reading
   bit                    jq [128];                // Last fractional request
   int                    err_total = 0;
   int                    cmp_count = 0;

   always #2 mclk_in = ~mclk_in;

   tef_extract_flow #(.FRAME_CYCLES(16)) DUT (
      .mclk_in(mclk_in), .rst_in(rst_in), .bus_in(bus), .rd_data_out(rd), .link_in(lk),
      .answer_out(ans), .justify_request_out(jr), .depth_err_in(de), .manual_reset_in(mr),
      .link_reset_out(lr), .add_bus_frame_pulse_in(fp), .internal_bus_realign_in(ib),
      .irq_out(irq));
   tef_far_tx u_far (.mclk_in(mclk_in), .rst_in(rst_in), .justify_request_in(jr),
      .slow_in(slow), .take_in(lk.valid), .depth_out(fdep));

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask

   // Bus write; the model keeps what the block should hold
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge mclk_in);
      bus <= '0;
      if (a inside {[12'h01d8:12'h01dd]}) rm[a] = d;
      if (a == 12'h01df) cfg = d & 8'hc0;
      if (a == 12'h01f0) au = d[0];
   endtask

   // Bus read; data stands only in the cycle after the strobe
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk_in);
      bus <= '0;
      #1 chk($sformatf("reg %h", a), rd, e);
   endtask

   // One visit, answer predicted from the levels of the link's rate
   task automatic visit(input tef_pkg::tef_link_s l);
      int s, up, ft, ix;
      logic [7:0] t;
      tef_pkg::tef_answer_s e;
      ix = {l.payload_group_index, l.link};
      t  = rm[12'h01da + l.rate];
      s  = 4'((l.rate[1] ? rm[12'h01d9] : rm[12'h01d8]) >> (4 * l.rate[0]));
      up = t[3:0] + (l.rate[1] ? 16 : 0);
      ft = cfg[6] ? 256 : 32;
      if (l.depth == 0) st[ix] = 0;
      e = '{1'b1, l.payload_group_index, l.link, (st[ix] || l.depth >= s) && l.depth != 0,
            l.master && !l.fractional && l.depth > up,
            l.master && !l.fractional && l.depth < t[7:4], 1'b0, l.depth == 0 && !cfg[7]};
      st[ix] = e.read_ok;
      if (l.fractional && l.depth != ft) jq[ix] = l.depth < ft;
      e.justify_req = l.fractional && jq[ix];
      @(posedge mclk_in);
      lk <= l;
      @(posedge mclk_in);
      lk <= '0;
      #1 chk("answer", ans, e);
      chk("request", jr, e.justify_req);
   endtask

   // Error or manual reset pulse; a reset clears the started state
   task automatic ev(input logic m, input logic [1:0] s, input logic [4:0] k);
      @(posedge mclk_in);
      if (m) mr <= '{1'b1, s, k};
      else de <= '{1'b1, s, k};
      @(posedge mclk_in);
      de <= '0;
      mr <= '0;
      if (m || au) st[{s, k}] = 0;
      if (m || au) jq[{s, k}] = 1'b1;
      #1 chk("link reset", lr, (m || au) ? {1'b1, s, k} : 8'h00);
   endtask

   task automatic strobe_ib();
      @(posedge mclk_in);
      ib <= 1'b1;
      @(posedge mclk_in);
      ib <= 1'b0;
   endtask

   // Partner feeds one link; depth must settle just above the level
   task automatic flow(input logic sl, input int ft);
      int mx;
      mx = 0;
      slow = sl;
      for (int i = 0; i < 400; i++) begin
         visit('{1'b1, 2'b10, 5'h09, tef_pkg::TEF_RATE_E1, 1'b0, 1'b1, fdep});
         if (i >= 300 && fdep > mx) mx = fdep;
      end
      chk("peak depth", mx >= ft && mx <= ft + 16, 1'b1);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      #100000;
      err_total++;
      finish_test();
   end

   initial begin
      tef_pkg::tef_link_s l;
      void'($urandom(32'h6fcc_0af9));
      for (int i = 0; i < 128; i++) jq[i] = 1'b1;
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rm[12'h01d8 + 12'(i)] = i == 0 ? 8'h77 : i == 1 ? 8'hfe : 8'h2d;
         rdc(12'h01d8 + 12'(i), rm[12'h01d8 + 12'(i)]);
      end
      wr(12'h01de, 8'hff);
      wr(12'h0100, 8'hff);
      rdc(12'h01de, 8'h00);
      rdc(12'h01df, 8'h00);
      rdc(12'h01f0, 8'h01);
      rdc(12'h0100, 8'h00);
      wr(12'h01df, 8'h80);
      rdc(12'h01df, 8'h80);
      flow(1'b0, 32);
      wr(12'h01df, 8'hc0);
      flow(1'b1, 256);
      // Random levels, all four config settings, random visits
      for (int c = 0; c < 4; c++) begin
         for (int i = 0; i < 6; i++) wr(12'h01d8 + 12'(i), 8'($urandom));
         wr(12'h01df, 8'(c << 6));
         rdc(12'h01dc, rm[12'h01dc]);
         repeat (80) begin
            l = '{1'b1, 2'(1 + $urandom % 3), 5'(1 + $urandom % 4),
                  tef_pkg::tef_rate_e'($urandom % 4), 1'($urandom), 1'($urandom),
                  10'($urandom % 2 ? $urandom % 40 : 240 + $urandom % 40)};
            visit(l);
         end
      end
      // Depth errors: highest link first, one entry per read
      wr(12'h01d8, 8'h77);
      wr(12'h01f1, 8'h07);
      ev(1'b0, 2'b01, 5'h05);
      ev(1'b0, 2'b11, 5'h1c);
      ev(1'b0, 2'b01, 5'h05);
      chk("irq", irq, 1'b1);
      rdc(12'h01de, 8'hf9);
      rdc(12'h01de, 8'h4b);
      rdc(12'h01de, 8'h00);
      rdc(12'h01f2, 8'h01);
      wr(12'h01f0, 8'h00);
      visit('{1'b1, 2'b10, 5'h03, tef_pkg::TEF_RATE_T1, 1'b0, 1'b0, 10'h014});
      ev(1'b0, 2'b10, 5'h03);
      ev(1'b1, 2'b10, 5'h03);
      visit('{1'b1, 2'b10, 5'h03, tef_pkg::TEF_RATE_T1, 1'b0, 1'b0, 10'h001});
      rdc(12'h01de, 8'h87);
      // Realignments: steady frame pulses lock, a shifted one is flagged
      strobe_ib();
      repeat (4) begin
         @(posedge mclk_in);
         fp <= 1'b1;
         @(posedge mclk_in);
         fp <= 1'b0;
         repeat (14) @(posedge mclk_in);
      end
      repeat (8) @(posedge mclk_in);
      rdc(12'h01df, 8'hc2);
      @(posedge mclk_in);
      fp <= 1'b1;
      @(posedge mclk_in);
      fp <= 1'b0;
      repeat (6) @(posedge mclk_in);
      rdc(12'h01df, 8'hc1);
      rdc(12'h01df, 8'hc0);
      rdc(12'h01f2, 8'h07);
      rdc(12'h01f2, 8'h00);
      chk("irq", irq, 1'b0);
      wr(12'h01f1, 8'h00);
      strobe_ib();
      repeat (3) @(posedge mclk_in);
      chk("irq", irq, 1'b0);
      rdc(12'h01f2, 8'h04);
      finish_test();
   end
endmodule
